// file: rdc_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// R01 - chip reset comes from reset pin, watchdog timeout or software request
// R02 - software must not request reset while running in slow clock mode
// R03 - at power-up the pin is held low at least 700 us
// R04 - cold reset hold time is configurable for oscillator settling; cold hold is fixed by COLD_CYC, osch_q sets only the hold after pin reset
// R05 - pin low for 12 or more clocks is a valid warm reset
// R06 - warm reset returns control registers to reset values
// R07 - debug, cause flag and flash security state clear on cold reset only
// R08 - pll multiplier is off after any reset until software enables it
// R09 - core starts the reset routine when reset processing ends
// R10 - ram contents are not kept through reset
// R11 - debug tool traffic refused while the reset pin is asserted
// R12 - tool sets breakpoints then requests software reset to stop at vector
// R13 - after reset the five shared pins carry their debug functions
// R14 - software avoids moving debug pins to ports right after reset
// R15 - six debug pin sets; unused pins become general-purpose ports
// R16 - watchdog frozen while core is halted; other peripherals run
// R17 - internal reset release is synchronised to the system clock
module rdc_top #(
    parameter int COLD_CYC = rdc_pkg::SETTLE_CYC,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic rst_pin_n,
    input wire logic wdt_timeout,
    input wire logic sw_system_reset_request,
    input wire logic core_halted,
    output logic chip_rst_n,
    output logic debug_rst_n,
    output logic fetch_start,
    output logic pll_en,
    output logic [rdc_pkg::PIN_W-1:0] dbg_pin_func,
    output logic dbg_link_en,
    output logic wdt_freeze,
    output logic flash_sec,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [rdc_pkg::HOLD_W-1:0] COLD_LOAD = rdc_pkg::HOLD_W'(COLD_CYC);
    localparam logic [rdc_pkg::HOLD_W-1:0] WARM_LOAD = rdc_pkg::HOLD_W'(rdc_pkg::WARM_CYC);

    rdc_pkg::rdc_state_t state_q, state_d;
    rdc_pkg::rdc_flags_t flags_q, flags_d, set_v;
    rdc_pkg::rdc_dbg_cfg_t cfg_q, cfg_d;
    logic pin_low, pin_reset, tmr_start, tmr_done;
    logic [rdc_pkg::HOLD_W-1:0] tmr_load, osch_q, osch_d;
    logic crst_q, crst_d, drst_q, fetch_q, fetch_d;
    logic pll_q, pll_d, swreq_q, swreq_d, link_q, freeze_q, fsec_q, fsec_d;
    logic [rdc_pkg::PIN_W-1:0] mask_q, mask_d;
    logic [ADDR_W-1:0] aw_q, aw_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d, cur, nv, wm;
    logic [3:0] ws_q, ws_d;
    logic awok_q, awok_d, wok_q, wok_d, awr_q, awr_d, wr_q, wr_d;
    logic bv_q, bv_d, arr_q, arr_d, rv_q, rv_d, wr_fire, wr_hit, rd_hit;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [31:0] rd_val;

    // ------------------------------------------------------------
    // reset pin filter and hold timer
    // ------------------------------------------------------------
    rdc_pin_filter #(.MIN_CYC(rdc_pkg::PIN_MIN_CYC)) u_pin (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .rst_pin_n(rst_pin_n),
        .pin_low(pin_low),
        .pin_reset(pin_reset)
    );

    rdc_hold_timer #(.W(rdc_pkg::HOLD_W), .INIT(COLD_LOAD)) u_hold (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(tmr_start),
        .load(tmr_load),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    // cold entry holds for COLD_CYC; pin entry waits for release then osc hold
    always_comb begin
        state_d = state_q;
        tmr_start = 1'b0;
        tmr_load = '0;
        fetch_d = 1'b0;
        set_v = '0;
        case (state_q)
            rdc_pkg::ST_HOLD: begin
                if (pin_reset) begin
                    state_d = rdc_pkg::ST_PIN;
                    set_v.pin = 1'b1;
                end else if (tmr_done) begin
                    state_d = rdc_pkg::ST_RUN; // [R17]
                    fetch_d = 1'b1; // [R09]
                end
            end
            rdc_pkg::ST_RUN: begin
                if (pin_reset) begin
                    state_d = rdc_pkg::ST_PIN; // [R01] [R05]
                    set_v.pin = 1'b1;
                end else if (wdt_timeout) begin
                    state_d = rdc_pkg::ST_HOLD; // [R01]
                    tmr_start = 1'b1;
                    tmr_load = WARM_LOAD;
                    set_v.wdt = 1'b1;
                end else if (sw_system_reset_request || swreq_q) begin
                    state_d = rdc_pkg::ST_HOLD; // [R01] [R12]
                    tmr_start = 1'b1;
                    tmr_load = WARM_LOAD;
                    set_v.sw = 1'b1;
                end
            end
            rdc_pkg::ST_PIN: begin
                if (!pin_low) begin
                    state_d = rdc_pkg::ST_HOLD; // [R04]
                    tmr_start = 1'b1;
                    tmr_load = osch_q;
                end
            end
            default: state_d = rdc_pkg::ST_HOLD;
        endcase
        // ram is left untouched; its contents are undefined after release [R10]
        crst_d = (state_d == rdc_pkg::ST_RUN); // [R06] [R17]
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= rdc_pkg::ST_HOLD;
            crst_q <= 1'b0;
            drst_q <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            crst_q <= crst_d;
            drst_q <= 1'b1; // [R07]
            fetch_q <= fetch_d;
        end
    end

    // ------------------------------------------------------------
    // debug pins, link gate and watchdog freeze
    // ------------------------------------------------------------
    // map the pin set to per-pin debug function enables
    always_comb begin
        case (cfg_d) // [R15]
            rdc_pkg::DBG_JTAG_SW: mask_d = rdc_pkg::MASK_JTAG_SW; // [R13]
            rdc_pkg::DBG_JTAG_NOTRST: mask_d = rdc_pkg::MASK_JTAG_NOTRST;
            rdc_pkg::DBG_JTAG_TRACE: mask_d = rdc_pkg::MASK_JTAG_TRACE;
            rdc_pkg::DBG_SW: mask_d = rdc_pkg::MASK_SW;
            rdc_pkg::DBG_SW_VIEW: mask_d = rdc_pkg::MASK_SW_VIEW;
            default: mask_d = rdc_pkg::MASK_OFF;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mask_q <= rdc_pkg::MASK_JTAG_SW;
            link_q <= 1'b0;
            freeze_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            link_q <= !pin_low; // [R11]
            freeze_q <= core_halted; // [R16]
        end
    end

    // ------------------------------------------------------------
    // axi4-lite handshakes
    // ------------------------------------------------------------
    assign wr_fire = awok_q && wok_q && !bv_q;

    // address and data are taken in either order; response follows both
    always_comb begin
        aw_d = aw_q;
        wd_d = wd_q;
        ws_d = ws_q;
        awok_d = awok_q;
        wok_d = wok_q;
        bv_d = bv_q;
        br_d = br_q;
        if (s_axi_awvalid && awr_q) begin
            aw_d = s_axi_awaddr;
            awok_d = 1'b1;
        end
        if (s_axi_wvalid && wr_q) begin
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
            wok_d = 1'b1;
        end
        if (wr_fire) begin
            awok_d = 1'b0;
            wok_d = 1'b0;
            bv_d = 1'b1;
            br_d = wr_hit ? rdc_pkg::RESP_OKAY : rdc_pkg::RESP_SLVERR;
        end else if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        awr_d = !awok_d && !bv_d;
        wr_d = !wok_d && !bv_d;
        arr_d = arr_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_arvalid && arr_q) begin
            arr_d = 1'b0;
            rv_d = 1'b1;
            rd_d = rd_val;
            rr_d = rd_hit ? rdc_pkg::RESP_OKAY : rdc_pkg::RESP_SLVERR;
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
            arr_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            aw_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            awok_q <= 1'b0;
            wok_q <= 1'b0;
            awr_q <= 1'b1;
            wr_q <= 1'b1;
            bv_q <= 1'b0;
            br_q <= rdc_pkg::RESP_OKAY;
            arr_q <= 1'b1;
            rv_q <= 1'b0;
            rd_q <= '0;
            rr_q <= rdc_pkg::RESP_OKAY;
        end else begin
            aw_q <= aw_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            awok_q <= awok_d;
            wok_q <= wok_d;
            awr_q <= awr_d;
            wr_q <= wr_d;
            bv_q <= bv_d;
            br_q <= br_d;
            arr_q <= arr_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // read view of one register; unmapped offsets read zero
    function automatic logic [32:0] reg_view(input logic [ADDR_W-1:0] a);
        logic [11:0] o;
        logic [32:0] v;
        o = a[11:0];
        v = '0;
        if (o == rdc_pkg::OFS_CTRL) begin
            v[32] = 1'b1;
            v[rdc_pkg::CTRL_PLL] = pll_q;
            v[rdc_pkg::CTRL_CFG +: 3] = cfg_q;
        end else if (o == rdc_pkg::OFS_STAT) begin
            v[32] = 1'b1;
            v[4:0] = {link_q, freeze_q, core_halted, pin_low, crst_q};
            v[rdc_pkg::STAT_STATE +: 2] = state_q;
        end else if (o == rdc_pkg::OFS_FLAG) begin
            v = {1'b1, 28'h0000000, flags_q};
        end else if (o == rdc_pkg::OFS_FSEC) begin
            v = {1'b1, 31'h00000000, fsec_q};
        end else if (o == rdc_pkg::OFS_OSCH) begin
            v = {1'b1, 12'h000, osch_q};
        end
        return v;
    endfunction

    // writes, warm reset override and hardware flag set
    always_comb begin
        {rd_hit, rd_val} = reg_view(s_axi_araddr);
        {wr_hit, cur} = reg_view(aw_q);
        wm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
        nv = (cur & ~wm) | (wd_q & wm);
        pll_d = pll_q;
        cfg_d = cfg_q;
        swreq_d = swreq_q;
        flags_d = flags_q;
        fsec_d = fsec_q;
        osch_d = osch_q;
        if (wr_fire) begin
            if (aw_q[11:0] == rdc_pkg::OFS_CTRL) begin
                pll_d = nv[rdc_pkg::CTRL_PLL]; // [R08]
                if (nv[rdc_pkg::CTRL_CFG +: 3] <= 3'(rdc_pkg::DBG_OFF)) begin
                    cfg_d = rdc_pkg::rdc_dbg_cfg_t'(nv[rdc_pkg::CTRL_CFG +: 3]); // [R15]
                end
                swreq_d = nv[rdc_pkg::CTRL_SWRST]; // [R12]
            end else if (aw_q[11:0] == rdc_pkg::OFS_FLAG) begin
                flags_d = flags_q & ~nv[3:0];
            end else if (aw_q[11:0] == rdc_pkg::OFS_FSEC) begin
                fsec_d = nv[0];
            end else if (aw_q[11:0] == rdc_pkg::OFS_OSCH) begin
                osch_d = nv[rdc_pkg::HOLD_W-1:0]; // [R04]
            end
        end
        flags_d = flags_d | set_v; // set wins over clear
        if (!crst_d) begin
            pll_d = 1'b0; // [R06] [R08]
            cfg_d = rdc_pkg::DBG_JTAG_SW; // [R13]
            swreq_d = 1'b0;
        end
    end

    // flags, security bit and osc hold are reset by cold reset only
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pll_q <= 1'b0;
            cfg_q <= rdc_pkg::DBG_JTAG_SW;
            swreq_q <= 1'b0;
            flags_q <= rdc_pkg::FLAGS_RST; // [R07]
            fsec_q <= 1'b0;
            osch_q <= rdc_pkg::OSCH_RST;
        end else begin
            pll_q <= pll_d;
            cfg_q <= cfg_d;
            swreq_q <= swreq_d;
            flags_q <= flags_d;
            fsec_q <= fsec_d;
            osch_q <= osch_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign chip_rst_n = crst_q;
    assign debug_rst_n = drst_q;
    assign fetch_start = fetch_q;
    assign pll_en = pll_q;
    assign dbg_pin_func = mask_q;
    assign dbg_link_en = link_q;
    assign wdt_freeze = freeze_q;
    assign flash_sec = fsec_q;
    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bresp = br_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign s_axi_rvalid = rv_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    source_reset_a: assert property ( // [R01]
        state_q == rdc_pkg::ST_RUN && !pin_reset && (wdt_timeout || sw_system_reset_request)
        |=> !chip_rst_n ##1 !chip_rst_n)
        else $error("reset source did not reset chip");
    pll_off_a: assert property (!chip_rst_n |-> !pll_en) // [R08]
        else $error("pll enabled during reset");
    cold_only_a: assert property ( // [R07]
        !chip_rst_n && !wr_fire |=> $stable(flash_sec) && $stable(osch_q))
        else $error("cold-only state changed by warm reset");
    fetch_start_a: assert property ($rose(chip_rst_n) |-> fetch_start) // [R09]
        else $error("no fetch at reset release");
    link_block_a: assert property (pin_low |=> !dbg_link_en) // [R11]
        else $error("debug link open during pin reset");
    pins_default_a: assert property ( // [R13]
        !chip_rst_n |-> dbg_pin_func == rdc_pkg::MASK_JTAG_SW)
        else $error("debug pins not in default set");
    wdt_freeze_a: assert property ($past(rstn) |-> wdt_freeze == $past(core_halted)) // [R16]
        else $error("watchdog freeze does not follow halt");
    sync_release_a: assert property ( // [R17]
        $rose(chip_rst_n) |-> !$past(pin_reset) && $past(state_q) == rdc_pkg::ST_HOLD)
        else $error("reset released outside hold end");
    warm_clear_a: assert property ($fell(chip_rst_n) |-> cfg_q == rdc_pkg::DBG_JTAG_SW) // [R06]
        else $error("control not reset by warm reset");

    pin_seq_c: cover property ($rose(pin_reset) ##[1:300] $rose(chip_rst_n));
    wdt_seq_c: cover property (state_q == rdc_pkg::ST_RUN && wdt_timeout ##[1:40] fetch_start);
    sw_seq_c: cover property (wr_fire && swreq_d ##[1:40] fetch_start);
    cfg_chg_c: cover property (chip_rst_n && dbg_pin_func == rdc_pkg::MASK_JTAG_TRACE);
endmodule

// file: rdc_pkg.sv
package rdc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int SETTLE_US = 700;    // regulator settling time, microseconds
    localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000) + 0);
    localparam int PIN_MIN_CYC = 12;   // shortest pin pulse taken as a warm reset
    localparam int WARM_CYC = 16;      // internal hold after watchdog or software reset
    localparam int HOLD_W = 20;
    localparam logic [HOLD_W-1:0] OSCH_RST = 20'h00010;

    // ------------------------------------------------------------
    // register offsets and fields
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_FLAG = 12'h008;
    localparam logic [11:0] OFS_FSEC = 12'h00c;
    localparam logic [11:0] OFS_OSCH = 12'h010;
    localparam int CTRL_PLL = 0;
    localparam int CTRL_CFG = 4;
    localparam int CTRL_SWRST = 8;
    localparam int STAT_STATE = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // debug pin sets: bit 0 tms/swdio, 1 tck/swclk, 2 tdo/viewer,
    // 3 tdi, 4 trst, 5 trace clock, 9..6 trace data
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DBG_JTAG_SW,
        DBG_JTAG_NOTRST,
        DBG_JTAG_TRACE,
        DBG_SW,
        DBG_SW_VIEW,
        DBG_OFF
    } rdc_dbg_cfg_t;
    localparam int PIN_W = 10;
    localparam logic [PIN_W-1:0] MASK_JTAG_SW = 10'h01f;
    localparam logic [PIN_W-1:0] MASK_JTAG_NOTRST = 10'h00f;
    localparam logic [PIN_W-1:0] MASK_JTAG_TRACE = 10'h3ff;
    localparam logic [PIN_W-1:0] MASK_SW = 10'h003;
    localparam logic [PIN_W-1:0] MASK_SW_VIEW = 10'h007;
    localparam logic [PIN_W-1:0] MASK_OFF = 10'h000;

    typedef struct packed {
        logic sw;
        logic wdt;
        logic pin;
        logic cold;
    } rdc_flags_t;
    localparam rdc_flags_t FLAGS_RST = 4'h1;

    typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_PIN} rdc_state_t;

endpackage

// file: rdc_pin_filter.sv
`timescale 1ns/1ps
module rdc_pin_filter #(
    parameter int MIN_CYC = rdc_pkg::PIN_MIN_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic rst_pin_n,
    output logic pin_low,
    output logic pin_reset
);
    localparam int CW = $clog2(MIN_CYC + 1);
    logic s1_q, s1_d, low_q, low_d, rst_q, rst_d;
    logic [CW-1:0] cnt_q, cnt_d;

    // two-flop sync, then count consecutive low cycles
    always_comb begin
        s1_d = rst_pin_n;
        low_d = !s1_q;
        cnt_d = '0;
        if (low_q) begin
            cnt_d = (cnt_q == CW'(MIN_CYC)) ? cnt_q : cnt_q + CW'(1);
        end
        rst_d = low_q && (cnt_q >= CW'(MIN_CYC - 1)); // [R05]
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s1_q <= 1'b1;
            low_q <= 1'b0;
            cnt_q <= '0;
            rst_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            low_q <= low_d;
            cnt_q <= cnt_d;
            rst_q <= rst_d;
        end
    end

    assign pin_low = low_q;
    assign pin_reset = rst_q;

    pulse_len_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R05]
        $rose(rst_q) |-> $past(low_q, 12) && !$past(low_q, 13))
        else $error("pin reset taken after wrong low length");
endmodule

// file: rdc_hold_timer.sv
`timescale 1ns/1ps
module rdc_hold_timer #(
    parameter int W = rdc_pkg::HOLD_W,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic done
);
    logic [W-1:0] cnt_q, cnt_d;

    // load on start, count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = load;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_q <= INIT;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0);

    hold_not_early_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R04]
        start |=> cnt_q == $past(load))
        else $error("hold count not loaded on start");
endmodule

// file: rdc_far_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// external reset circuit on the active-low reset pin
// ------------------------------------------------------------
module rdc_far_model #(
    parameter int PWRUP_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic [7:0] len,
    output logic rst_pin_n
);
    logic [7:0] cnt_q = 8'(PWRUP_CYC);
    logic [7:0] cnt_d;

    // low count: power-up hold first, then one pulse per go
    always_comb begin
        cnt_d = cnt_q;
        if (go) begin
            cnt_d = len;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always @(posedge sys_clk) begin
        cnt_q <= cnt_d;
    end

    // pin low while counting, pull-up level once released
    assign rst_pin_n = (cnt_q == 8'h00);
endmodule

// file: rdc_top_tb.sv
`timescale 1ns/1ps
module rdc_top_tb;
    logic sys_clk = 1'h0, rstn = 1'h0, pin_go = 1'h0;
    logic wdt_timeout = 1'h0, sw_system_reset_request = 1'h0, core_halted = 1'h0;
    logic rst_pin_n, chip_rst_n, debug_rst_n, fetch_start, pll_en, dbg_link_en;
    logic wdt_freeze, flash_sec;
    logic [9:0] dbg_pin_func;
    logic [7:0] pin_len = 8'h00;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0] xf [4] = '{4'h2, 4'h4, 4'h8, 4'h8};
    int miscompares = 0, tests_run = 0, seed = 32'h1e7a7454, n;

    always #10 sys_clk = ~sys_clk;

    rdc_top #(.COLD_CYC(20)) dut_u (.sys_clk, .rstn, .rst_pin_n, .wdt_timeout,
        .sw_system_reset_request, .core_halted, .chip_rst_n, .debug_rst_n, .fetch_start,
        .pll_en, .dbg_pin_func, .dbg_link_en, .wdt_freeze, .flash_sec, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    rdc_far_model far_u (.sys_clk, .go(pin_go), .len(pin_len), .rst_pin_n);

    // expected pin functions of each pin set code
    function automatic logic [9:0] exp_mask(input int c);
        case (c)
            0: return rdc_pkg::MASK_JTAG_SW;
            1: return rdc_pkg::MASK_JTAG_NOTRST;
            2: return rdc_pkg::MASK_JTAG_TRACE;
            3: return rdc_pkg::MASK_SW;
            4: return rdc_pkg::MASK_SW_VIEW;
            default: return rdc_pkg::MASK_OFF;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // bus write: address and data offered together, each dropped when taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
    endtask

    task automatic axr(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    task automatic pin(input int k);
        pin_go <= 1'h1;
        pin_len <= k[7:0];
        @(posedge sys_clk);
        pin_go <= 1'h0;
    endtask

    // wait for chip reset release, fetch must start on that edge
    task automatic wait_rel;
        n = 0;
        while (chip_rst_n !== 1'h1 && n < 500) begin
            @(posedge sys_clk);
            n++;
        end
        chk("fetch_start", fetch_start, 1);
    endtask

    // hang guard
    initial begin
        cyc(20000);
        miscompares++;
        summarize;
    end

    // main sequence
    initial begin
        cyc(2);
        rstn <= 1'h1;
        chk("chip_rst_n", chip_rst_n, 0);
        chk("pins", dbg_pin_func, rdc_pkg::MASK_JTAG_SW);
        chk("pll_en", pll_en, 0);
        wait_rel;
        axr(rdc_pkg::OFS_FLAG);
        chk("cold flag", rd[0], 1);
        axr(rdc_pkg::OFS_STAT);
        chk("status", rd, 32'h111);
        // every pin set, pll bit drawn at random; pins set well after reset
        for (int c = 0; c < 7; c++) begin
            n = $random(seed);
            axw(rdc_pkg::OFS_CTRL, {c[2:0], 3'h0, n[0]} & 32'h71);
            cyc(2);
            chk("pins", dbg_pin_func, exp_mask(c < 6 ? c : 5));
            chk("pll_en", pll_en, n[0]);
        end
        axw(12'h020, 32'h1);
        chk("bresp", rsp, rdc_pkg::RESP_SLVERR);
        axr(12'h020);
        chk("rdata", rd, 32'h0);
        chk("rresp", rsp, rdc_pkg::RESP_SLVERR);
        core_halted <= 1'h1;
        cyc(3);
        chk("freeze", {wdt_freeze, chip_rst_n}, 2'h3);
        core_halted <= 1'h0;
        cyc(3);
        chk("freeze", wdt_freeze, 0);
        // short pin pulses are not resets
        repeat (4) begin
            n = 1 + {$random(seed)} % 11;
            pin(n);
            cyc(n + 8);
            chk("short pulse", chip_rst_n, 1);
        end
        axw(rdc_pkg::OFS_FSEC, 32'h1);
        axw(rdc_pkg::OFS_OSCH, 32'h20);
        axr(rdc_pkg::OFS_OSCH);
        chk("osch", rd, 32'h20);
        // each reset source in turn; security, debug units and flags survive
        for (int s = 0; s < 4; s++) begin
            axw(rdc_pkg::OFS_CTRL, 32'h31);
            axw(rdc_pkg::OFS_FLAG, 32'hf);
            case (s)
                0: pin(12);
                1: begin
                    wdt_timeout <= 1'h1;
                    @(posedge sys_clk);
                    wdt_timeout <= 1'h0;
                end
                // fast clock only, so a software request is allowed
                2: begin
                    sw_system_reset_request <= 1'h1;
                    @(posedge sys_clk);
                    sw_system_reset_request <= 1'h0;
                end
                3: axw(rdc_pkg::OFS_CTRL, 32'h100);
            endcase
            cyc(5);
            if (s == 0) chk("link", dbg_link_en, 0);
            n = 0;
            while (chip_rst_n !== 1'h0 && n < 40) begin
                @(posedge sys_clk);
                n++;
            end
            chk("chip_rst_n", chip_rst_n, 0);
            wait_rel;
            if (s == 0) chk("pin hold", n, 34);
            chk("warm", {pll_en, dbg_pin_func}, {1'h0, rdc_pkg::MASK_JTAG_SW});
            chk("kept", {flash_sec, debug_rst_n, dbg_link_en}, 3'h7);
            axr(rdc_pkg::OFS_FLAG);
            chk("flags", rd[3:0], xf[s]);
            axr(rdc_pkg::OFS_CTRL);
            chk("ctrl", rd, 32'h0);
        end
        // cold reset in mid-run clears the cold-only state
        rstn <= 1'h0;
        cyc(2);
        rstn <= 1'h1;
        chk("cold", {flash_sec, debug_rst_n}, 2'h0);
        wait_rel;
        axr(rdc_pkg::OFS_FLAG);
        chk("cold flags", rd[3:0], 4'h1);
        summarize;
    end
endmodule
